// ### src/psi_pkg.sv
// Constants and carrier types for the port status and interrupt register block.
// Contract
// - Status error event sets bit 15, W1C
// - Command error sets bit 14, kind in secondary
// - Frame deposited in host sets bit 13
// - Transmit ring done or error sets bit 12
// - Completed port command sets bit 11
// - No host buffer: bit 10, local counter pulse
// - Internal buffer overflow: bit 10, counter pulse
// - Fatal sets bit 9; bit 5 resets port
// - Boot or halt sets bit 8, state shown
// - Summary bit 7 is OR of flags
// - No interrupt while enable bit clear
// - Command zero does nothing, no done
// - Codes 1 and 2 start block fetches
// - Start enters running; if running only done
// - Selftest outcome sets done, change or fatal
package psi_pkg;
  localparam int          AW           = 4;
  localparam logic [3:0]  OFF_CSR0     = 4'h0;
  localparam logic [3:0]  OFF_SEC      = 4'h1;
  localparam logic [3:0]  OFF_MASK     = 4'h2;
  localparam int          FLAG_LSB     = 8;
  localparam int          POS_SUM      = 7;
  localparam int          POS_INTERRUPT_ENABLE_BIT     = 6;
  localparam int          POS_PORT_RESET_BIT     = 5;
  localparam int          F_SERR       = 7;
  localparam int          F_CERR       = 6;
  localparam int          F_RX         = 5;
  localparam int          F_TX         = 4;
  localparam int          F_DONE       = 3;
  localparam int          F_BUF        = 2;
  localparam int          F_FATAL      = 1;
  localparam int          F_CHG        = 0;
  localparam logic [7:0]  MASK_RST     = 8'hff;
  localparam logic [3:0]  CMD_NOOP     = 4'h0;
  localparam logic [3:0]  CMD_FETCH    = 4'h1;
  localparam logic [3:0]  CMD_ANCIL    = 4'h2;
  localparam logic [3:0]  CMD_SELFTEST = 4'h3;
  localparam logic [3:0]  CMD_START    = 4'h4;
  localparam logic [3:0]  CMD_BOOT     = 4'h5;
  localparam logic [3:0]  ST_READY     = 4'h1;
  localparam logic [3:0]  ST_RUN       = 4'h2;
  localparam logic [3:0]  ST_LOAD      = 4'h3;
  localparam logic [3:0]  ST_HALT      = 4'h4;
  localparam logic [5:0]  CNT_LOCAL_W  = 6'h20;
  localparam logic [5:0]  CNT_INTBUF_W = 6'h1e;

  typedef struct packed {
    logic       stat_err;
    logic       rx_deposit;
    logic       tx_ring_done;
    logic       tx_err;
    logic       no_host_buf;
    logic       int_buf_full;
    logic       fatal_err;
    logic       boot_frame;
    logic       net_halt;
    logic       cmd_done;
    logic       cmd_fail;
    logic       cmd_timeout;
    logic       st_pass;
    logic       st_fail_soft;
    logic       st_fail_fatal;
    logic [7:0] st_code;
  } psi_evt_t;

  typedef struct packed {
    logic       go;
    logic [3:0] code;
  } psi_cmd_t;
endpackage

// ### src/psi_port_status.sv
// Port control/status register with sticky interrupt flags and command issue.
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`default_nettype none
module psi_port_status
(
  input  wire logic               clk,
  input  wire logic               arst_n,
  input  wire logic [psi_pkg::AW-1:0] addr,
  input  wire logic [15:0]        wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  input  wire psi_pkg::psi_evt_t  ev,
  output var  logic [15:0]        rdata,
  output var  logic               irq,
  output var  psi_pkg::psi_cmd_t  cmd,
  output var  logic               lost_local_inc,
  output var  logic               lost_intbuf_inc,
  output var  logic               port_reset
);

  typedef enum logic [1:0] {
    PSI_IDLE = 2'b01,
    PSI_BUSY = 2'b10
  } psi_fsm_t;

  psi_fsm_t    fsm;
  psi_fsm_t    next_fsm;
  logic [7:0]  flags;
  logic [7:0]  next_flags;
  logic [7:0]  mask;
  logic [7:0]  next_mask;
  logic        interrupt_enable_bit;
  logic        next_interrupt_enable_bit;
  logic [3:0]  state;
  logic [3:0]  next_state;
  logic        err_kind;
  logic        next_err_kind;
  logic [7:0]  err_code;
  logic [7:0]  next_err_code;
  logic [15:0] next_rdata;
  logic        next_irq;
  psi_pkg::psi_cmd_t next_cmd;
  logic        next_lost_local;
  logic        next_lost_intbuf;
  logic        next_port_reset;
  logic [7:0]  set_vec;
  logic        wr_csr0;
  logic        rst_req;
  logic        cmd_req;
  logic        st_end;

  function automatic logic hit(input logic [psi_pkg::AW-1:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  assign wr_csr0 = wr && hit(addr, psi_pkg::OFF_CSR0);
  assign rst_req = wr_csr0 && wdata[psi_pkg::POS_PORT_RESET_BIT];
  assign cmd_req = wr_csr0 && !rst_req && (wdata[3:0] != psi_pkg::CMD_NOOP);
  assign st_end  = ev.st_pass || ev.st_fail_soft || ev.st_fail_fatal;

  // Hardware events collected into the flag layout; a set in the cycle of a clear wins.
  always_comb
  begin
    set_vec                   = 8'h00;
    set_vec[psi_pkg::F_SERR]  = ev.stat_err;
    set_vec[psi_pkg::F_CERR]  = (fsm == PSI_BUSY) && (ev.cmd_fail || ev.cmd_timeout);
    set_vec[psi_pkg::F_RX]    = ev.rx_deposit;
    set_vec[psi_pkg::F_TX]    = ev.tx_ring_done || ev.tx_err;
    set_vec[psi_pkg::F_DONE]  = ((fsm == PSI_BUSY) && ev.cmd_done) || ev.st_pass;
    set_vec[psi_pkg::F_BUF]   = ev.no_host_buf || ev.int_buf_full;
    set_vec[psi_pkg::F_FATAL] = ev.fatal_err || ev.st_fail_fatal;
    set_vec[psi_pkg::F_CHG]   = ev.boot_frame || ev.net_halt || ev.st_fail_soft;
    if (fsm == PSI_IDLE && cmd_req && wdata[3:0] == psi_pkg::CMD_START && state == psi_pkg::ST_RUN)
    begin
      set_vec[psi_pkg::F_DONE] = 1'b1;
    end
  end

  // Register state: flags, enable, mask, port state and secondary status.
  always_comb
  begin
    next_flags    = flags;
    next_mask     = mask;
    next_interrupt_enable_bit     = interrupt_enable_bit;
    next_state    = state;
    next_err_kind = err_kind;
    next_err_code = err_code;
    if (rst_req)
    begin
      // Port reset drops all pending causes and returns the port to ready unless a boot frame or halt arrives in the same cycle.
      next_flags = 8'h00;
      next_interrupt_enable_bit  = 1'b0;
      next_state = psi_pkg::ST_READY;
    end
    else if (wr_csr0)
    begin
      next_flags = flags & ~wdata[15:8];
      if (!cmd_req)
      begin
        // A command write leaves the enable alone, so the two never change together.
        next_interrupt_enable_bit = wdata[psi_pkg::POS_INTERRUPT_ENABLE_BIT];
      end
    end
    next_flags = next_flags | set_vec;
    if (wr && hit(addr, psi_pkg::OFF_MASK))
    begin
      next_mask = wdata[15:8];
    end
    if (fsm == PSI_BUSY && (ev.cmd_fail || ev.cmd_timeout))
    begin
      next_err_kind = ev.cmd_timeout;
    end
    if (ev.st_fail_soft)
    begin
      next_err_code = ev.st_code;
    end
    // A port reset in the same cycle wins over the completion of the command in flight.
    if (!rst_req && fsm == PSI_BUSY && ev.cmd_done && cmd.code == psi_pkg::CMD_START)
    begin
      next_state = psi_pkg::ST_RUN;
    end
    // Any selftest outcome ends the command, so a soft failure still leaves the port taking commands.
    if (!rst_req && fsm == PSI_BUSY && (ev.cmd_done || st_end) && cmd.code == psi_pkg::CMD_SELFTEST)
    begin
      next_state = psi_pkg::ST_READY;
    end
    if (ev.boot_frame)
    begin
      next_state = psi_pkg::ST_LOAD;
    end
    if (ev.net_halt)
    begin
      next_state = psi_pkg::ST_HALT;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flags    <= 8'h00;
      mask     <= psi_pkg::MASK_RST;
      interrupt_enable_bit     <= 1'b0;
      state    <= psi_pkg::ST_READY;
      err_kind <= 1'b0;
      err_code <= 8'h00;
    end
    else
    begin
      flags    <= next_flags;
      mask     <= next_mask;
      interrupt_enable_bit     <= next_interrupt_enable_bit;
      state    <= next_state;
      err_kind <= next_err_kind;
      err_code <= next_err_code;
    end
  end

  // Command issue: one command in flight; new command writes while busy are dropped.
  always_comb
  begin
    next_fsm         = fsm;
    next_cmd         = cmd;
    next_cmd.go      = 1'b0;
    next_port_reset  = rst_req;
    next_lost_local  = ev.no_host_buf;
    next_lost_intbuf = ev.int_buf_full;
    case (fsm)
      PSI_IDLE:
      begin
        if (cmd_req && !(wdata[3:0] == psi_pkg::CMD_START && state == psi_pkg::ST_RUN))
        begin
          next_cmd.go   = 1'b1;
          next_cmd.code = wdata[3:0];
          next_fsm      = PSI_BUSY;
        end
      end
      PSI_BUSY:
      begin
        if (rst_req || ev.cmd_done || ev.cmd_fail || ev.cmd_timeout ||
            (st_end && cmd.code == psi_pkg::CMD_SELFTEST))
        begin
          next_fsm = PSI_IDLE;
        end
      end
      default:
      begin
        next_fsm = PSI_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fsm             <= PSI_IDLE;
      cmd             <= '0;
      port_reset      <= 1'b0;
      lost_local_inc  <= 1'b0;
      lost_intbuf_inc <= 1'b0;
    end
    else
    begin
      fsm             <= next_fsm;
      cmd             <= next_cmd;
      port_reset      <= next_port_reset;
      lost_local_inc  <= next_lost_local;
      lost_intbuf_inc <= next_lost_intbuf;
    end
  end

  // Read port and interrupt line.
  always_comb
  begin
    next_rdata = 16'h0000;
    if (rd && hit(addr, psi_pkg::OFF_CSR0))
    begin
      next_rdata[15:8]             = flags;
      next_rdata[psi_pkg::POS_SUM]  = |flags;
      next_rdata[psi_pkg::POS_INTERRUPT_ENABLE_BIT] = interrupt_enable_bit;
      next_rdata[3:0]              = cmd.code;
    end
    else if (rd && hit(addr, psi_pkg::OFF_SEC))
    begin
      next_rdata = {err_code, err_kind, 3'h0, state};
    end
    else if (rd && hit(addr, psi_pkg::OFF_MASK))
    begin
      next_rdata = {mask, 8'h00};
    end
    // Registered from next values so irq tracks the flags without an extra cycle.
    next_irq = next_interrupt_enable_bit && |(next_flags & next_mask);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata <= 16'h0000;
      irq   <= 1'b0;
    end
    else
    begin
      rdata <= next_rdata;
      irq   <= next_irq;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_start_running;
    fsm == PSI_IDLE && cmd_req && wdata[3:0] == psi_pkg::CMD_START && state == psi_pkg::ST_RUN;
  endsequence

  sequence s_cmd_issue;
    fsm == PSI_IDLE && cmd_req && !(wdata[3:0] == psi_pkg::CMD_START && state == psi_pkg::ST_RUN);
  endsequence

  sequence s_selftest_end;
    fsm == PSI_BUSY && cmd.code == psi_pkg::CMD_SELFTEST && st_end && !rst_req && !ev.boot_frame && !ev.net_halt;
  endsequence

  a_w1c_clear: assert property (wr_csr0 && !rst_req && wdata[15] && !set_vec[7] |=> !flags[7])
    else $error("status error flag not cleared by write one");
  a_zero_keeps: assert property (wr_csr0 && !rst_req && flags[5] && !wdata[13] |=> flags[5])
    else $error("receive flag lost on write zero");
  a_rx_sets: assert property (ev.rx_deposit |=> flags[psi_pkg::F_RX])
    else $error("receive flag not set");
  a_summary_or: assert property (rd && hit(addr, psi_pkg::OFF_CSR0) |=> rdata[7] == |$past(flags))
    else $error("summary bit differs from flag OR");
  a_irq_gate: assert property (!interrupt_enable_bit |-> !irq)
    else $error("interrupt while enable clear");
  a_irq_cause: assert property (interrupt_enable_bit && |(flags & mask) |-> irq)
    else $error("interrupt missing with enabled cause");
  a_noop_quiet: assert property (wr_csr0 && !rst_req && wdata[3:0] == 4'h0 && fsm == PSI_IDLE |=> !cmd.go)
    else $error("no-op issued a command");
  a_start_done: assert property (s_start_running |=> flags[psi_pkg::F_DONE] && !cmd.go)
    else $error("start while running not just done");
  a_cmd_pulse: assert property (s_cmd_issue |=> cmd.go ##1 !cmd.go)
    else $error("command strobe not one cycle");
  a_lost_local: assert property (ev.no_host_buf |=> lost_local_inc && flags[psi_pkg::F_BUF])
    else $error("local buffer loss not reported");
  a_lost_intbuf: assert property (ev.int_buf_full |=> lost_intbuf_inc && flags[psi_pkg::F_BUF])
    else $error("internal buffer loss not reported");
  a_reset_bit: assert property (rst_req && !ev.boot_frame && !ev.net_halt |=> port_reset && state == psi_pkg::ST_READY)
    else $error("port reset bit not honoured");
  a_halt_state: assert property (ev.net_halt |=> state == psi_pkg::ST_HALT && flags[psi_pkg::F_CHG])
    else $error("halt state change not shown");
  a_fatal_sets: assert property (ev.fatal_err |=> flags[psi_pkg::F_FATAL])
    else $error("fatal flag not set");
  a_serr_sets: assert property (ev.stat_err |=> flags[psi_pkg::F_SERR])
    else $error("status error flag not set");
  a_cerr_sets: assert property (fsm == PSI_BUSY && (ev.cmd_fail || ev.cmd_timeout) |=> flags[psi_pkg::F_CERR] && err_kind == $past(ev.cmd_timeout))
    else $error("command error not reported");
  a_tx_sets: assert property (ev.tx_ring_done || ev.tx_err |=> flags[psi_pkg::F_TX])
    else $error("transmit flag not set");
  a_done_sets: assert property (fsm == PSI_BUSY && ev.cmd_done |=> flags[psi_pkg::F_DONE])
    else $error("done flag not set on completion");
  a_busy_drop: assert property (fsm == PSI_BUSY && cmd_req |=> !cmd.go)
    else $error("command issued while busy");
  a_selftest_end: assert property (s_selftest_end |=> fsm == PSI_IDLE && state == psi_pkg::ST_READY)
    else $error("selftest outcome did not end the command");
  a_soft_code: assert property (ev.st_fail_soft |=> err_code == $past(ev.st_code) && flags[psi_pkg::F_CHG])
    else $error("selftest error code not kept");

endmodule
`default_nettype wire

// ### verif/psi_host_model.sv
// Host-side bus model that issues register cycles to the port status block.
`timescale 1ns/100ps
`default_nettype none
module psi_host_model
(
  input  wire logic                   clk,
  input  wire logic [15:0]            rdata,
  output var  logic [psi_pkg::AW-1:0] addr,
  output var  logic [15:0]            wdata,
  output var  logic                   wr,
  output var  logic                   rd
);
  initial
  begin
    addr = '0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end

  // One strobe cycle, then a released edge, so two tasks never collide in one time step.
  // Callers never put the enable bit and a command code in one write
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
endmodule
`default_nettype wire

// ### verif/port_status_interrupt_reg_tb.sv
// Self-checking bench for the port status and interrupt register block.
`timescale 1ns/100ps
`default_nettype none
module port_status_interrupt_reg_tb;
  logic              clk, arst_n, wr, rd, irq, lost_local_inc, lost_intbuf_inc, port_reset;
  logic [3:0]        addr;
  logic [15:0]       wdata, rdata, v;
  psi_pkg::psi_evt_t ev;
  psi_pkg::psi_cmd_t cmd;
  int                num_errors, cmp_count, flags, interrupt_enable_bit, mask, i, lcode, sc;
  int                evb[9] = '{22, 21, 20, 19, 18, 17, 16, 15, 14};
  int                fb[9] = '{15, 13, 12, 12, 10, 10, 9, 8, 8};

  psi_port_status u_psi_port_status (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .ev(ev), .rdata(rdata), .irq(irq), .cmd(cmd), .lost_local_inc(lost_local_inc),
    .lost_intbuf_inc(lost_intbuf_inc), .port_reset(port_reset));
  psi_host_model u_psi_host_model (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

  task automatic stop_test();
    if (num_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  // The command field reads back the last code actually issued; a port reset leaves it alone.
  task automatic csr_chk();
    u_psi_host_model.rd_reg(4'h0, v);
    chk("csr0", v, 16'(((flags & 255) << 8) | (int'(flags != 0) << 7) | (interrupt_enable_bit << 6) | lcode));
  endtask

  task automatic sec_chk(input logic [15:0] e);
    u_psi_host_model.rd_reg(4'h1, v);
    chk("secondary", v, e);
  endtask

  task automatic irq_chk();
    chk("irq", 16'(irq), 16'(interrupt_enable_bit != 0 && (flags & mask) != 0));
  endtask

  task automatic wr0(input logic [15:0] d);
    u_psi_host_model.wr_reg(4'h0, d);
    flags = flags & ~int'(d[15:8]);
    if (d[3:0] == 4'h0)
      interrupt_enable_bit = d[6];
  endtask

  task automatic pulse(input int b, input logic [7:0] c = 8'h00);
    @(posedge clk);
    ev <= psi_pkg::psi_evt_t'((23'h1 << b) | 23'(c));
    @(posedge clk);
    ev <= '0;
    #1;
  endtask

  task automatic cmdw(input logic [3:0] c, input bit go);
    wr0((c == 4'h0) ? 16'(interrupt_enable_bit << 6) : 16'(c));
    #1 chk("go", 16'(cmd.go), 16'(go));
    if (go)
    begin
      lcode = c;
      chk("code", 16'(cmd.code), 16'(c));
    end
  endtask

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    #3000000;
    num_errors++;
    stop_test();
  end

  initial
  begin
    arst_n = 1'b0;
    ev = '0;
    flags = 0;
    interrupt_enable_bit = 0;
    mask = 255;
    lcode = 0;
    void'($urandom(64371));
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    csr_chk();
    u_psi_host_model.rd_reg(4'h2, v);
    chk("mask", v, 16'hff00);
    sec_chk(16'h0001);
    u_psi_host_model.wr_reg(4'h7, 16'hffff);
    u_psi_host_model.rd_reg(4'h7, v);
    chk("unmapped", v, 16'h0000);
    csr_chk();
    for (i = 0; i < 9; i++)
    begin
      pulse(evb[i]);
      flags |= 1 << (fb[i] - 8);
      irq_chk();
      chk("lost_local", 16'(lost_local_inc), 16'(evb[i] == 18));
      chk("lost_intbuf", 16'(lost_intbuf_inc), 16'(evb[i] == 17));
      csr_chk();
      // Writing zeros over the flags must leave every one of them standing.
      wr0(16'(interrupt_enable_bit << 6));
      csr_chk();
      if (i > 6)
        sec_chk(16'(i - 4));
      if (i == 3)
        wr0(16'h0040);
    end
    repeat (4)
    begin
      mask = $urandom_range(0, 255);
      u_psi_host_model.wr_reg(4'h2, 16'(mask << 8));
      @(posedge clk);
      #1 irq_chk();
    end
    for (i = 8; i < 16; i++)
    begin
      wr0(16'(1 << i) | 16'h0040);
      csr_chk();
      irq_chk();
    end
    cmdw(4'h4, 1);
    pulse(13);
    flags |= 8;
    csr_chk();
    sec_chk(16'h0002);
    wr0(16'h0840);
    cmdw(4'h4, 0);
    flags |= 8;
    csr_chk();
    wr0(16'h0840);
    cmdw(4'h0, 0);
    csr_chk();
    cmdw(4'h1, 1);
    pulse(11);
    flags |= 64;
    sec_chk(16'h0082);
    cmdw(4'h2, 1);
    // A second command while one is in flight is dropped and the field keeps the first code.
    cmdw(4'h1, 0);
    csr_chk();
    pulse(12);
    sec_chk(16'h0002);
    cmdw(4'h3, 1);
    pulse(10);
    flags |= 8;
    csr_chk();
    sec_chk(16'h0001);
    u_psi_host_model.wr_reg(4'h0, 16'h0020);
    #1 chk("port_reset", 16'(port_reset), 16'h0001);
    flags = 0;
    interrupt_enable_bit = 0;
    csr_chk();
    chk("port_reset", 16'(port_reset), 16'h0000);
    irq_chk();
    // Selftest failures: a soft one leaves a random code in the secondary word, a hard one raises fatal.
    sc = $urandom_range(1, 255);
    cmdw(4'h3, 1);
    pulse(9, 8'(sc));
    flags |= 1;
    csr_chk();
    sec_chk(16'((sc << 8) | 1));
    cmdw(4'h3, 1);
    pulse(8);
    flags |= 2;
    csr_chk();
    irq_chk();
    stop_test();
  end
endmodule
`default_nettype wire
